//--- mtc_pkg.sv
// Purpose: constants and carriers for the motion config register bank
// Assumes: byte-wide register port on the 100 MHz system clock
// Notes: offsets are the serial-interface register addresses
package mtc_pkg;
  // register offsets
  localparam logic [6:0] OFF_ENG_CTL = 7'h25;
  localparam logic [6:0] OFF_ENG_CFG = 7'h26;
  localparam logic [6:0] OFF_WOM = 7'h27;
  localparam logic [6:0] OFF_BUF = 7'h28;
  localparam logic [6:0] OFF_WM_LO = 7'h29;
  localparam logic [6:0] OFF_WM_HI = 7'h2A;
  localparam logic [6:0] OFF_R1A = 7'h2B;
  localparam logic [6:0] OFF_R1B = 7'h2C;
  localparam logic [6:0] OFF_R2A = 7'h2D;
  localparam logic [6:0] OFF_R2B = 7'h2E;
  // reset values
  localparam logic [7:0] RST_ENG_CTL = 8'h08;
  localparam logic [7:0] RST_ENG_CFG = 8'h02;
  localparam logic [7:0] RST_BUF = 8'h01;
  localparam logic [7:0] RST_R1A = 8'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // writable bits; memory clear is a strobe and is not stored
  localparam logic [7:0] MSK_ENG_CTL = 8'h0C;
  localparam logic [7:0] MSK_ENG_CFG = 8'h7B;
  localparam logic [7:0] MSK_WOM = 8'h1F;
  localparam logic [7:0] MSK_WOM_HOLD = 8'h1E;
  localparam logic [7:0] MSK_BUF = 8'h03;
  localparam logic [7:0] MSK_WM_HI = 8'h0F;
  localparam logic [7:0] MSK_RB = 8'h4F;
  // field positions
  localparam int BIT_PWR_SAVE = 3;
  localparam int BIT_ENG_EN = 2;
  localparam int BIT_MEM_CLR = 0;
  localparam int BIT_SIG_MOTION = 6;
  localparam int BIT_FF = 5;
  localparam int BIT_TILT = 4;
  localparam int BIT_STEP = 3;
  localparam int BIT_RATE = 0;
  localparam int BIT_WOM_CNT = 3;
  localparam int BIT_WOM_AND = 2;
  localparam int BIT_WOM_REF = 1;
  localparam int BIT_WAKE_ON = 0;
  localparam int BIT_STOP_FULL = 1;
  localparam int BIT_BYPASS = 0;
  localparam int BIT_THS = 2;
  // engine rates and divider counts
  localparam int CLK_HZ = 100_000_000;
  localparam int RATE_25_HZ = 25;
  localparam int RATE_50_HZ = 50;
  localparam int RATE_100_HZ = 100;
  localparam int RATE_400_HZ = 400;
  localparam int CYC_25 = CLK_HZ / RATE_25_HZ;
  localparam int CYC_50 = CLK_HZ / RATE_50_HZ;
  localparam int CYC_100 = CLK_HZ / RATE_100_HZ;
  localparam int CYC_400 = CLK_HZ / RATE_400_HZ;
  // carriers
  typedef struct packed {
    logic we;
    logic re;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mtc_req_t;
  typedef struct packed {
    logic [7:0] prim;
    logic proto_err;
    logic sig_motion;
    logic [2:0] wake;
  } mtc_pend_t;
  typedef struct packed {
    logic power_save;
    logic engine_on;
    logic mem_clear;
    logic sig_motion_on;
    logic freefall_on;
    logic tilt_on;
    logic step_on;
    logic [1:0] rate;
    logic wake_on;
    logic wake_reference_select;
    logic stop_on_full;
    logic bypass;
  } mtc_ctl_t;
  typedef struct packed {
    logic [7:0] eng_ctl;
    logic [7:0] eng_cfg;
    logic [7:0] wom_cfg;
    logic [7:0] buf_cfg;
    logic [7:0] wm_lo;
    logic [7:0] wm_hi;
    logic [7:0] r1a;
    logic [7:0] r1b;
    logic [7:0] r2a;
    logic [7:0] r2b;
    logic [7:0] rdata;
    logic mem_clr;
    logic [21:0] div;
    logic tick;
    logic [1:0] wcnt;
    logic ref_held;
    logic ref_load;
    logic [2:0] wevt;
    logic above;
    logic wm_evt;
    logic irq1;
    logic irq2;
  } mtc_state_t;
endpackage

//--- mtc_regs.sv
// Purpose: configuration bank for the motion engine, wake, buffer, irq routing
// Assumes: register port and event inputs are on clk_sys
// Notes: status flags live outside; this bank routes their pending levels
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - engine power-save bit 3 enables power saving for engine algorithms.
// - engine enable bit 2 starts the engine; changeable at any time.
// - writing 1 to bit 0 clears the engine working memory.
// - detector enables: motion bit 6, freefall 5, tilt 4, step counter 3.
// - engine rate code 00=25, 01=400, 10=50, 11=100 Hz.
// - wake count field delays wake interrupt to 2nd, 3rd or 4th event.
// - combine bit 0 uses OR of enabled axes, 1 uses AND.
// - reference bit 0 compares to first sample, 1 to previous sample.
// - wake config bit 0 enables wake-on-motion detection.
// - overflow bit 0 overwrites oldest data, 1 stops when full.
// - bypass bit 0 bypasses buffer when set; resets to bypass.
// - 12-bit watermark over two registers flags level at or above it.
// - watermark event fires once per crossing, not while level stays high.
// - pin one primary routing, bit per source, resets to 0x10.
// - pin one secondary routing: protocol error 6, motion 3, Z/Y/X 2:0.
// - pin two primary routing, same layout, resets to zero.
// - pin two secondary bit 6 routes protocol error; bits 5:4 reserved.
// - pin two secondary bits 3:0 route motion and Z/Y/X wake events.
// - count format bit selects bytes or records for watermark and level.
module mtc_regs #(
  parameter logic [21:0] CYC_25 = 22'(mtc_pkg::CYC_25),
  parameter logic [21:0] CYC_50 = 22'(mtc_pkg::CYC_50),
  parameter logic [21:0] CYC_100 = 22'(mtc_pkg::CYC_100),
  parameter logic [21:0] CYC_400 = 22'(mtc_pkg::CYC_400)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port from the serial interface
  input wire mtc_pkg::mtc_req_t req,
  output logic [7:0] rdata,
  // wake comparator
  input wire logic wom_sample,
  input wire logic [2:0] wom_over,
  input wire logic [2:0] wom_axis_en,
  output logic wom_ref_load,
  output logic [2:0] wom_event,
  // buffer level
  input wire logic [11:0] level_bytes,
  input wire logic [11:0] level_records,
  input wire logic count_in_records,
  output logic wm_event,
  // engine
  output mtc_pkg::mtc_ctl_t ctl,
  output logic engine_tick,
  // interrupts
  input wire mtc_pkg::mtc_pend_t pend,
  output logic irq_pin_one,
  output logic irq_pin_two
);

  mtc_pkg::mtc_state_t s_r;
  mtc_pkg::mtc_state_t s_nxt;
  logic [7:0] rd;
  logic [11:0] lvl;
  logic hit;

  // divider end count for the selected engine rate
  function automatic logic [21:0] rate_limit(input logic [1:0] c);
    case (c)
      2'h0: rate_limit = CYC_25 - 22'h1;
      2'h1: rate_limit = CYC_400 - 22'h1;
      2'h2: rate_limit = CYC_50 - 22'h1;
      default: rate_limit = CYC_100 - 22'h1;
    endcase
  endfunction

  // reserved code 00 is treated like 01: second event
  function automatic logic [1:0] wake_need(input logic [1:0] c);
    wake_need = (c == 2'h0) ? 2'h1 : c;
  endfunction

  // pending events gated by one pin's two routing registers
  function automatic logic route_hit(input mtc_pkg::mtc_pend_t p,
                                     input logic [7:0] a, input logic [7:0] b);
    route_hit = |(p.prim & a) | |({1'b0, p.proto_err, 2'b00, p.sig_motion, p.wake} & b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_clr = 1'b0;
    s_nxt.tick = 1'b0;
    s_nxt.ref_load = 1'b0;
    s_nxt.wevt = 3'h0;
    // register writes; reserved bits never stored so they read zero
    if (req.we) begin
      if (req.addr == mtc_pkg::OFF_ENG_CTL) begin
        s_nxt.eng_ctl = req.wdata & mtc_pkg::MSK_ENG_CTL;
        s_nxt.mem_clr = req.wdata[mtc_pkg::BIT_MEM_CLR];
      end else if (req.addr == mtc_pkg::OFF_ENG_CFG) begin
        s_nxt.eng_cfg = req.wdata & mtc_pkg::MSK_ENG_CFG;
      end else if (req.addr == mtc_pkg::OFF_WOM) begin
        // hold count/combine/reference while armed so a stray write cannot retune
        if (s_r.wom_cfg[mtc_pkg::BIT_WAKE_ON]) begin
          s_nxt.wom_cfg = (req.wdata & mtc_pkg::MSK_WOM & ~mtc_pkg::MSK_WOM_HOLD)
                          | (s_r.wom_cfg & mtc_pkg::MSK_WOM_HOLD);
        end else begin
          s_nxt.wom_cfg = req.wdata & mtc_pkg::MSK_WOM;
        end
      end else if (req.addr == mtc_pkg::OFF_BUF) begin
        s_nxt.buf_cfg = req.wdata & mtc_pkg::MSK_BUF;
      end else if (req.addr == mtc_pkg::OFF_WM_LO) begin
        s_nxt.wm_lo = req.wdata;
      end else if (req.addr == mtc_pkg::OFF_WM_HI) begin
        s_nxt.wm_hi = req.wdata & mtc_pkg::MSK_WM_HI;
      end else if (req.addr == mtc_pkg::OFF_R1A) begin
        s_nxt.r1a = req.wdata;
      end else if (req.addr == mtc_pkg::OFF_R1B) begin
        s_nxt.r1b = req.wdata & mtc_pkg::MSK_RB;
      end else if (req.addr == mtc_pkg::OFF_R2A) begin
        s_nxt.r2a = req.wdata;
      end else if (req.addr == mtc_pkg::OFF_R2B) begin
        s_nxt.r2b = req.wdata & mtc_pkg::MSK_RB;
      end
    end
    // read mux; unmapped addresses read zero
    if (req.addr == mtc_pkg::OFF_ENG_CTL) begin
      rd = s_r.eng_ctl;
    end else if (req.addr == mtc_pkg::OFF_ENG_CFG) begin
      rd = s_r.eng_cfg;
    end else if (req.addr == mtc_pkg::OFF_WOM) begin
      rd = s_r.wom_cfg;
    end else if (req.addr == mtc_pkg::OFF_BUF) begin
      rd = s_r.buf_cfg;
    end else if (req.addr == mtc_pkg::OFF_WM_LO) begin
      rd = s_r.wm_lo;
    end else if (req.addr == mtc_pkg::OFF_WM_HI) begin
      rd = s_r.wm_hi;
    end else if (req.addr == mtc_pkg::OFF_R1A) begin
      rd = s_r.r1a;
    end else if (req.addr == mtc_pkg::OFF_R1B) begin
      rd = s_r.r1b;
    end else if (req.addr == mtc_pkg::OFF_R2A) begin
      rd = s_r.r2a;
    end else if (req.addr == mtc_pkg::OFF_R2B) begin
      rd = s_r.r2b;
    end else begin
      rd = 8'h00;
    end
    if (req.re) begin
      s_nxt.rdata = rd;
    end
    // engine sample-rate divider, held at zero while the engine is off
    if (s_r.eng_ctl[mtc_pkg::BIT_ENG_EN]) begin
      if (s_r.div >= rate_limit(s_r.eng_cfg[mtc_pkg::BIT_RATE +: 2])) begin
        s_nxt.div = 22'h0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.div = s_r.div + 22'h1;
      end
    end else begin
      s_nxt.div = 22'h0;
    end
    // wake-on-motion: consecutive over-threshold samples are counted
    if (s_r.wom_cfg[mtc_pkg::BIT_WOM_AND]) begin
      hit = (wom_axis_en != 3'h0) && ((wom_over & wom_axis_en) == wom_axis_en);
    end else begin
      hit = |(wom_over & wom_axis_en);
    end
    if (!s_r.wom_cfg[mtc_pkg::BIT_WAKE_ON]) begin
      s_nxt.wcnt = 2'h0;
      s_nxt.ref_held = 1'b0;
    end else if (wom_sample) begin
      // first sample only, or every sample, becomes the reference
      s_nxt.ref_load = s_r.wom_cfg[mtc_pkg::BIT_WOM_REF] | ~s_r.ref_held;
      s_nxt.ref_held = 1'b1;
      if (!hit) begin
        s_nxt.wcnt = 2'h0;
      end else if (s_r.wcnt == wake_need(s_r.wom_cfg[mtc_pkg::BIT_WOM_CNT +: 2])) begin
        s_nxt.wevt = wom_over & wom_axis_en;
        s_nxt.wcnt = 2'h0;
      end else begin
        s_nxt.wcnt = s_r.wcnt + 2'h1;
      end
    end
    // watermark: enabled by routing the threshold source to either pin
    lvl = count_in_records ? level_records : level_bytes;
    s_nxt.above = (s_r.r1a[mtc_pkg::BIT_THS] | s_r.r2a[mtc_pkg::BIT_THS])
                  & ~s_r.buf_cfg[mtc_pkg::BIT_BYPASS]
                  & (lvl >= {s_r.wm_hi[3:0], s_r.wm_lo});
    s_nxt.wm_evt = s_nxt.above & ~s_r.above;
    // pins follow pending sources through their routing masks
    s_nxt.irq1 = route_hit(pend, s_r.r1a, s_r.r1b);
    s_nxt.irq2 = route_hit(pend, s_r.r2a, s_r.r2b);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.eng_ctl <= mtc_pkg::RST_ENG_CTL;
      s_r.eng_cfg <= mtc_pkg::RST_ENG_CFG;
      s_r.buf_cfg <= mtc_pkg::RST_BUF;
      s_r.r1a <= mtc_pkg::RST_R1A;
      s_r.r2a <= mtc_pkg::RST_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign rdata = s_r.rdata;
  assign engine_tick = s_r.tick;
  assign wom_ref_load = s_r.ref_load;
  assign wom_event = s_r.wevt;
  assign wm_event = s_r.wm_evt;
  assign irq_pin_one = s_r.irq1;
  assign irq_pin_two = s_r.irq2;
  assign ctl.power_save = s_r.eng_ctl[mtc_pkg::BIT_PWR_SAVE];
  assign ctl.engine_on = s_r.eng_ctl[mtc_pkg::BIT_ENG_EN];
  assign ctl.mem_clear = s_r.mem_clr;
  assign ctl.sig_motion_on = s_r.eng_cfg[mtc_pkg::BIT_SIG_MOTION];
  assign ctl.freefall_on = s_r.eng_cfg[mtc_pkg::BIT_FF];
  assign ctl.tilt_on = s_r.eng_cfg[mtc_pkg::BIT_TILT];
  assign ctl.step_on = s_r.eng_cfg[mtc_pkg::BIT_STEP];
  assign ctl.rate = s_r.eng_cfg[mtc_pkg::BIT_RATE +: 2];
  assign ctl.wake_on = s_r.wom_cfg[mtc_pkg::BIT_WAKE_ON];
  assign ctl.wake_reference_select = s_r.wom_cfg[mtc_pkg::BIT_WOM_REF];
  assign ctl.stop_on_full = s_r.buf_cfg[mtc_pkg::BIT_STOP_FULL];
  assign ctl.bypass = s_r.buf_cfg[mtc_pkg::BIT_BYPASS];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence clr_write_s;
    req.we && req.addr == mtc_pkg::OFF_ENG_CTL && req.wdata[0];
  endsequence
  sequence clr_pulse_s;
    ctl.mem_clear ##1 !ctl.mem_clear;
  endsequence
  sequence buf_write_s;
    req.we && req.addr == mtc_pkg::OFF_BUF;
  endsequence

  mem_clear_pulse_a: assert property (clr_write_s |=> clr_pulse_s)
    else $error("memory clear not a single pulse");
  power_save_a: assert property (req.we && req.addr == mtc_pkg::OFF_ENG_CTL
    |=> ctl.power_save == $past(req.wdata[3]))
    else $error("power save bit not taken");
  tick_needs_engine_a: assert property (engine_tick |-> $past(ctl.engine_on))
    else $error("engine tick while engine off");
  // a stopped engine must restart its rate count from zero
  engine_off_div_a: assert property (!ctl.engine_on |=> s_r.div == 22'h0)
    else $error("divider ran while engine off");
  detector_enable_a: assert property (req.we && req.addr == mtc_pkg::OFF_ENG_CFG
    |=> ctl.tilt_on == $past(req.wdata[4]) && ctl.sig_motion_on == $past(req.wdata[6]))
    else $error("detector enable not taken");
  tick_spacing_a: assert property (engine_tick |=> !engine_tick [*2])
    else $error("engine ticks too close");
  wake_count_a: assert property (wom_event != 3'h0
    |-> $past(s_r.wcnt) == wake_need($past(s_r.wom_cfg[4:3])))
    else $error("wake fired at wrong count");
  wake_and_a: assert property (wom_event != 3'h0
    && $past(s_r.wom_cfg[mtc_pkg::BIT_WOM_AND]) |-> wom_event == $past(wom_axis_en))
    else $error("and mode fired without every enabled axis");
  // reloading the first-sample reference would hide slow drift from the comparator
  wake_ref_a: assert property (wom_ref_load |-> $past(wom_sample)
    && ($past(ctl.wake_reference_select) || !$past(s_r.ref_held)))
    else $error("reference loaded at wrong sample");
  wake_off_quiet_a: assert property (!ctl.wake_on |=> wom_event == 3'h0)
    else $error("wake event while disabled");
  wake_hold_a: assert property (ctl.wake_on && req.we && req.addr == mtc_pkg::OFF_WOM
    |=> $stable(s_r.wom_cfg[4:1]))
    else $error("wake settings changed while armed");
  buffer_mode_a: assert property (buf_write_s
    |=> ctl.stop_on_full == $past(req.wdata[1]) && ctl.bypass == $past(req.wdata[0]))
    else $error("buffer mode not taken");
  wm_level_a: assert property (wm_event
    |-> $past(lvl) >= $past({s_r.wm_hi[3:0], s_r.wm_lo}))
    else $error("watermark event below the watermark");
  wm_once_a: assert property (wm_event |=> !wm_event)
    else $error("watermark event repeated");
  bypass_no_wm_a: assert property (ctl.bypass |=> !wm_event)
    else $error("watermark event in bypass");
  pin_one_route_a: assert property (req.we && req.addr == mtc_pkg::OFF_R1A
    |=> s_r.r1a == $past(req.wdata))
    else $error("pin one routing not taken");
  // reserved routing bits stay zero so a later source cannot be enabled by accident
  reserved_zero_a: assert property (s_r.r1b[5:4] == 2'h0 && s_r.r2b[5:4] == 2'h0)
    else $error("reserved routing bits set");
  pin_route_a: assert property (##1
    irq_pin_one == $past(route_hit(pend, s_r.r1a, s_r.r1b))
    && irq_pin_two == $past(route_hit(pend, s_r.r2a, s_r.r2b)))
    else $error("irq pin does not follow routing");

endmodule

`default_nettype wire

//--- mtc_host.sv
// Purpose: host model that drives the register port of the config bank
// Assumes: requests launch 1 ns after the rising edge, one per call
// Notes: strobes drop after the taking edge, so back to back calls never overlap
`timescale 1ns/100ps
`default_nettype none
module mtc_host (
  // clock
  input wire logic clk_sys,
  // register port
  output mtc_pkg::mtc_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // callers clear routes before watermark writes; some wake edits are written while armed and held
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req.we = 1'b0;
  endtask
  // read data is registered at the taking edge, so it is ready on return
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1 req.re = 1'b0;
    d = rdata;
  endtask
endmodule
`default_nettype wire

//--- mtc_regs_tb.sv
// Purpose: self-checking bench for the motion config register bank
// Assumes: short engine divider counts so tick periods stay brief
// Notes: register model masks writes by hand; events come from the bench
`timescale 1ns/100ps
`default_nettype none
module mtc_regs_tb;
  localparam int T25 = 40;
  localparam int T50 = 20;
  localparam int T100 = 10;
  localparam int T400 = 4;
  logic clk_sys = 1'b0;
  logic rst_n;
  mtc_pkg::mtc_req_t req;
  mtc_pkg::mtc_ctl_t ctl;
  mtc_pkg::mtc_pend_t pend;
  logic [7:0] rdata, rnd, v;
  logic [2:0] wom_over, wom_axis_en, wom_event, h, p;
  logic wom_sample, wom_ref_load, count_in_records, wm_event, engine_tick;
  logic irq_pin_one, irq_pin_two;
  logic [11:0] level_bytes, level_records;
  logic [7:0] m [37:47];
  int n_mismatch = 0, compares = 0, cyc = 0, nev, n;
  ////////////////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  mtc_host host_u (.clk_sys(clk_sys), .req(req), .rdata(rdata));
  mtc_regs #(.CYC_25(22'd40), .CYC_50(22'd20), .CYC_100(22'd10), .CYC_400(22'd4)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata), .wom_sample(wom_sample),
    .wom_over(wom_over), .wom_axis_en(wom_axis_en), .wom_ref_load(wom_ref_load),
    .wom_event(wom_event), .level_bytes(level_bytes), .level_records(level_records),
    .count_in_records(count_in_records), .wm_event(wm_event), .ctl(ctl),
    .engine_tick(engine_tick), .pend(pend), .irq_pin_one(irq_pin_one),
    .irq_pin_two(irq_pin_two));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // writable bits; memory clear self-clears so it is not stored
  function automatic logic [7:0] msk(input int a);
    case (a)
      'h25: return 8'h0C;
      'h26: return 8'h7B;
      'h27: return 8'h1F;
      'h28: return 8'h03;
      'h2A: return 8'h0F;
      'h2C, 'h2E: return 8'h4F;
      'h29, 'h2B, 'h2D: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rv(input int a);
    return (a == 'h25) ? 8'h08 : (a == 'h26) ? 8'h02 : (a == 'h28) ? 8'h01 :
      (a == 'h2B) ? 8'h10 : 8'h00;
  endfunction
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // wake settings hold while detection is on, only the enable bit moves
  task automatic mwr(input int a, input logic [7:0] d);
    logic [7:0] k;
    k = (a == 'h27 && m[a][0]) ? 8'h01 : msk(a);
    host_u.wr(7'(a), d);
    m[a] = (m[a] & ~k) | (d & k);
  endtask
  task automatic rchk(input int a);
    host_u.rd(7'(a), v);
    chk($sformatf("reg %h", a), m[a], v);
  endtask
  task automatic ctlchk();
    chk("eng ctl", m['h25], {4'h0, ctl.power_save, ctl.engine_on, 2'h0});
    chk("eng cfg", m['h26], {1'b0, ctl.sig_motion_on, ctl.freefall_on, ctl.tilt_on,
      ctl.step_on, 1'b0, ctl.rate});
    chk("wake ctl", m['h27] & 8'h03, {6'h0, ctl.wake_reference_select, ctl.wake_on});
    chk("buf ctl", m['h28], {6'h0, ctl.stop_on_full, ctl.bypass});
  endtask
  task automatic gap(output int n);
    int k;
    k = 0;
    n = 0;
    while (engine_tick !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      #1 k++;
    end
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (engine_tick !== 1'b1 && n < 100);
  endtask
  task automatic samp(input logic [2:0] o, input bit e, input bit rl);
    @(posedge clk_sys);
    #1 wom_sample = 1'b1;
    wom_over = o;
    @(posedge clk_sys);
    #1 wom_sample = 1'b0;
    chk("wake event", {5'h0, e ? (o & wom_axis_en) : 3'h0}, {5'h0, wom_event});
    chk("ref load", {7'h0, rl}, {7'h0, wom_ref_load});
  endtask
  task automatic lvl(input bit r, input logic [11:0] b, input logic [11:0] q, input int c);
    count_in_records = r;
    level_bytes = b;
    level_records = q;
    repeat (c) begin
      @(posedge clk_sys);
      #1 nev += (wm_event === 1'b1);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // a hang ends the run through the same report
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      final_report();
    end
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {wom_sample, wom_over, wom_axis_en, count_in_records} = 8'h0E;
    {level_bytes, level_records} = '0;
    pend = '0;
    rnd = 8'h1F;
    for (int a = 'h25; a <= 'h2F; a++) m[a] = rv(a);
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (int a = 'h25; a <= 'h2F; a++) rchk(a);
    ctlchk();
    repeat (3) begin
      mwr('h2B, 8'h00);
      mwr('h2D, 8'h00);
      for (int a = 'h25; a <= 'h2F; a++) begin
        rnd = lfsr(rnd);
        mwr(a, rnd);
      end
      for (int a = 'h25; a <= 'h2F; a++) rchk(a);
      ctlchk();
    end
    mwr('h25, 8'h05);
    chk("mem clear", 8'h01, {7'h0, ctl.mem_clear});
    @(posedge clk_sys);
    #1 chk("mem clear", 8'h00, {7'h0, ctl.mem_clear});
    rchk('h25);
    for (int c = 0; c < 4; c++) begin
      mwr('h25, 8'h00);
      mwr('h26, 8'(c));
      mwr('h25, 8'h04);
      gap(n);
      chk("tick gap", 8'(c == 0 ? T25 : c == 1 ? T400 : c == 2 ? T50 : T100), 8'(n));
    end
    mwr('h27, 8'h00);
    for (int md = 0; md < 2; md++) for (int c = 1; c < 4; c++) begin
      mwr('h27, 8'(c * 8 + md * 6));
      mwr('h27, 8'(c * 8 + md * 6 + 1));
      mwr('h27, 8'h1F);
      rchk('h27);
      wom_axis_en = md ? 3'b101 : 3'b011;
      h = md ? 3'b111 : 3'b010;
      p = md ? 3'b011 : 3'b100;
      samp(h, 1'b0, 1'b1);
      samp(p, 1'b0, md[0]);
      for (int i = 0; i <= c; i++) samp(h, i == c, md[0]);
      mwr('h27, 8'(c * 8 + md * 6));
      samp(h, 1'b0, 1'b0);
    end
    mwr('h2B, 8'h00);
    mwr('h2D, 8'h00);
    mwr('h28, 8'h00);
    mwr('h29, 8'h05);
    mwr('h2A, 8'h01);
    mwr('h2B, 8'h04);
    nev = 0;
    lvl(1'b1, 12'hFFF, 12'h104, 6);
    chk("wm events", 8'd0, 8'(nev));
    lvl(1'b1, 12'hFFF, 12'h105, 8);
    lvl(1'b1, 12'hFFF, 12'h107, 8);
    chk("wm events", 8'd1, 8'(nev));
    lvl(1'b1, 12'hFFF, 12'h000, 4);
    lvl(1'b1, 12'hFFF, 12'h105, 8);
    chk("wm events", 8'd2, 8'(nev));
    lvl(1'b0, 12'h104, 12'hFFF, 6);
    lvl(1'b0, 12'h105, 12'hFFF, 6);
    chk("wm events", 8'd3, 8'(nev));
    lvl(1'b0, 12'h000, 12'h000, 4);
    mwr('h28, 8'h01);
    lvl(1'b0, 12'h105, 12'h000, 6);
    chk("wm events", 8'd3, 8'(nev));
    repeat (24) begin
      for (int a = 'h2B; a <= 'h2E; a++) begin
        rnd = lfsr(rnd);
        mwr(a, rnd);
      end
      rnd = lfsr(rnd);
      v = lfsr(rnd);
      pend = {rnd, v[4:0]};
      @(posedge clk_sys);
      #1 chk("irq one", {7'h0, |(m['h2B] & pend[12:5]) |
        |({m['h2C][6], m['h2C][3:0]} & pend[4:0])}, {7'h0, irq_pin_one});
      chk("irq two", {7'h0, |(m['h2D] & pend[12:5]) |
        |({m['h2E][6], m['h2E][3:0]} & pend[4:0])}, {7'h0, irq_pin_two});
      rnd = v;
    end
    final_report();
  end
endmodule
`default_nettype wire
